// ==== hw/doorbell_route_pkg.sv ====
// constants, register map and decode helpers for the partition event and doorbell routing block
package doorbell_route_pkg;
    // =====================================================
    // sizes
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int NUM_TARGET_PARTITION_SELECT = 8;
    localparam int NUM_GDB  = 32;
    localparam int NUM_FOVR = 4;
    localparam int NUM_MSG  = 4;
    localparam int DB_W     = NUM_TARGET_PARTITION_SELECT * NUM_GDB;
    // =====================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_FOVR_MASK = 12'hC2C;
    localparam logic [11:0] OFS_GSIG_STS  = 12'hC30;
    localparam logic [11:0] OFS_GSIG_MASK = 12'hC34;
    localparam logic [11:0] OFS_GDB_STS   = 12'hC3C;
    localparam logic [11:0] OFS_ODB_BASE  = 12'hD00;
    localparam logic [11:0] OFS_IDB_BASE  = 12'hD80;
    localparam logic [11:0] OFS_MSG_BASE  = 12'hE00;
    localparam logic [11:0] OFS_IRQ_STS   = 12'hE80;
    localparam logic [11:0] OFS_IRQ_EN    = 12'hE84;
    localparam logic [11:0] OFS_IRQ_CLR   = 12'hE88;
    localparam logic [11:0] ARRAY_MASK    = 12'hF80;
    // =====================================================
    // field positions
    localparam int FOVR_INIT_LSB = 0;
    localparam int FOVR_DONE_LSB = 16;
    localparam int MSG_REG_LSB   = 0;
    localparam int MSG_TARGET_PARTITION_SELECT_LSB  = 4;
    localparam int IRQ_GSIG_BIT  = 0;
    localparam int IRQ_GDB_BIT   = 1;
    localparam int IRQ_MSG_BIT   = 2;
    localparam int IRQ_W         = 3;
    // =====================================================
    // reset values
    localparam logic [3:0] FOVR_MASK_RST = 4'hF;
    localparam logic [7:0] GSIG_STS_RST  = 8'h00;
    localparam logic [7:0] GSIG_MASK_RST = 8'hFF;
    localparam logic [7:0] DB_MASK_RST   = 8'h00;
    localparam logic [1:0] MSG_REG_RST   = 2'h0;
    localparam logic [2:0] MSG_TARGET_PARTITION_SELECT_RST  = 3'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum {SEL_NONE, SEL_FOVR, SEL_GSTS, SEL_GMSK, SEL_GDB, SEL_ODB,
                  SEL_IDB, SEL_MSG, SEL_ISTS, SEL_IEN, SEL_ICLR} reg_sel_t;

    // map a byte address to the register it selects
    function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        if ((a & ARRAY_MASK) == OFS_ODB_BASE) return SEL_ODB;
        if ((a & ARRAY_MASK) == OFS_IDB_BASE) return SEL_IDB;
        if ((a & ARRAY_MASK) == OFS_MSG_BASE) return SEL_MSG;
        unique case (a)
            OFS_FOVR_MASK: return SEL_FOVR;
            OFS_GSIG_STS:  return SEL_GSTS;
            OFS_GSIG_MASK: return SEL_GMSK;
            OFS_GDB_STS:   return SEL_GDB;
            OFS_IRQ_STS:   return SEL_ISTS;
            OFS_IRQ_EN:    return SEL_IEN;
            OFS_IRQ_CLR:   return SEL_ICLR;
            default:       return SEL_NONE;
        endcase
    endfunction : reg_sel

    // expand byte strobes to a bit mask
    function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask
endpackage : doorbell_route_pkg

// ==== hw/partition_event_doorbell_routing.sv ====
// switch event masking, global signal status, global doorbells and message routing
// How it works
// - failover mask bits 0..3 block mode-change-initiated flags from the switch event; reset one
// - failover mask bits 16..19 block mode-change-completed flags from the switch event; reset one
// - eight global signal status bits, set per partition, cleared by writing one
// - status bits of disabled partitions never set and read zero
// - global signal mask bits block matching status from the switch event; reset all ones
// - read-only global doorbell status shows unmasked pending doorbell requests
// - per-doorbell outbound mask blocks a partition's outbound doorbell; resets zero
// - per-doorbell inbound mask blocks a doorbell reaching a partition; resets zero
// - route control bits 1:0 pick the destination inbound message register
// - route control bits 6:4 pick the destination partition
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module partition_event_doorbell_routing (
    input  wire logic                                REF_CLK_IN,
    input  wire logic                                ARST_N_IN,
    input  wire logic [doorbell_route_pkg::ADDR_W-1:0] AWADDR_IN,
    input  wire logic                                AWVALID_IN,
    output logic                                     AWREADY_OUT,
    input  wire logic [doorbell_route_pkg::DATA_W-1:0] WDATA_IN,
    input  wire logic [3:0]                          WSTRB_IN,
    input  wire logic                                WVALID_IN,
    output logic                                     WREADY_OUT,
    output logic [1:0]                               BRESP_OUT,
    output logic                                     BVALID_OUT,
    input  wire logic                                BREADY_IN,
    input  wire logic [doorbell_route_pkg::ADDR_W-1:0] ARADDR_IN,
    input  wire logic                                ARVALID_IN,
    output logic                                     ARREADY_OUT,
    output logic [doorbell_route_pkg::DATA_W-1:0]    RDATA_OUT,
    output logic [1:0]                               RRESP_OUT,
    output logic                                     RVALID_OUT,
    input  wire logic                                RREADY_IN,
    input  wire logic [3:0]                          FAILOVER_INITIATED_IN,
    input  wire logic [3:0]                          FAILOVER_COMPLETED_IN,
    input  wire logic [7:0]                          GLOBAL_SIGNAL_IN,
    input  wire logic [7:0]                          PARTITION_ENABLE_IN,
    input  wire logic [doorbell_route_pkg::DB_W-1:0] OUTBOUND_DOORBELL_IN,
    output logic [doorbell_route_pkg::DB_W-1:0]      INBOUND_DOORBELL_OUT,
    input  wire logic                                MSG_VALID_IN,
    input  wire logic [2:0]                          MSG_SRC_TARGET_PARTITION_SELECT_IN,
    input  wire logic [1:0]                          MSG_SRC_REG_IN,
    input  wire logic [doorbell_route_pkg::DATA_W-1:0] MSG_DATA_IN,
    output logic                                     MSG_VALID_OUT,
    output logic [2:0]                               MSG_DST_TARGET_PARTITION_SELECT_OUT,
    output logic [1:0]                               MSG_DST_REG_OUT,
    output logic [doorbell_route_pkg::DATA_W-1:0]    MSG_DATA_OUT,
    output logic                                     SWITCH_EVENT_OUT,
    output logic                                     IRQ_OUT
);
    import doorbell_route_pkg::*;

    // =====================================================
    // reset release
    logic                rst_meta_r;
    logic                rst_n;
    logic [3:0]          fovr_init_mask_r;
    logic [3:0]          fovr_done_mask_r;
    logic [7:0]          gsig_sts_r;
    logic [7:0]          gsig_mask_r;
    logic [NUM_GDB-1:0]  gdb_sts_r;
    logic [7:0]          odb_mask_r [NUM_GDB];
    logic [7:0]          idb_mask_r [NUM_GDB];
    logic [1:0]          msg_reg_r  [NUM_TARGET_PARTITION_SELECT*NUM_MSG];
    logic [2:0]          msg_target_partition_select_r [NUM_TARGET_PARTITION_SELECT*NUM_MSG];
    logic [IRQ_W-1:0]    irq_sts_r;
    logic [IRQ_W-1:0]    irq_en_r;
    logic [ADDR_W-1:0]   awaddr_r;
    logic [DATA_W-1:0]   wdata_r;
    logic [3:0]          wstrb_r;
    logic                do_write;
    reg_sel_t            wsel;
    logic [DATA_W-1:0]   wbits;
    logic [DATA_W-1:0]   wnew;
    logic [4:0]          widx;
    logic [NUM_GDB-1:0]  gdb_nxt;
    logic [DB_W-1:0]     ib_nxt;
    logic [7:0]          gsig_set;
    logic [7:0]          gsig_nxt;
    logic                event_nxt;
    logic [IRQ_W-1:0]    irq_ev;
    logic [4:0]          msg_idx;

    // two-stage release of the asynchronous reset
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // register contents as read back; reserved bits stay zero
    function automatic logic [DATA_W-1:0] rd_word(input reg_sel_t s, input logic [4:0] i);
        logic [DATA_W-1:0] d;
        d = '0;
        unique case (s)
            SEL_FOVR: begin
                d[FOVR_INIT_LSB +: NUM_FOVR] = fovr_init_mask_r;
                d[FOVR_DONE_LSB +: NUM_FOVR] = fovr_done_mask_r;
            end
            SEL_GSTS: d[7:0] = gsig_sts_r;
            SEL_GMSK: d[7:0] = gsig_mask_r;
            SEL_GDB:  d = gdb_sts_r;
            SEL_ODB:  d[7:0] = odb_mask_r[i];
            SEL_IDB:  d[7:0] = idb_mask_r[i];
            SEL_MSG: begin
                d[MSG_REG_LSB +: 2]  = msg_reg_r[i];
                d[MSG_TARGET_PARTITION_SELECT_LSB +: 3] = msg_target_partition_select_r[i];
            end
            SEL_ISTS: d[IRQ_W-1:0] = irq_sts_r;
            SEL_IEN:  d[IRQ_W-1:0] = irq_en_r;
            SEL_ICLR, SEL_NONE: d = '0;
        endcase
        return d;
    endfunction : rd_word

    // =====================================================
    // write channel: address and data taken in either order
    assign do_write = !AWREADY_OUT && !WREADY_OUT && !BVALID_OUT;
    assign wsel     = reg_sel(awaddr_r);
    assign widx     = awaddr_r[6:2];
    assign wbits    = wdata_r & strb_mask(wstrb_r);

    // old word merged with the enabled byte lanes; a process, so register updates are seen
    always_comb begin
        wnew = (rd_word(wsel, widx) & ~strb_mask(wstrb_r)) | wbits;
    end

    // accept address and data, answer once both are held
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            AWREADY_OUT <= 1'b1;
            WREADY_OUT  <= 1'b1;
            BVALID_OUT  <= 1'b0;
            BRESP_OUT   <= RESP_OKAY;
            awaddr_r    <= '0;
            wdata_r     <= '0;
            wstrb_r     <= '0;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                AWREADY_OUT <= 1'b0;
                awaddr_r    <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT) begin
                WREADY_OUT <= 1'b0;
                wdata_r    <= WDATA_IN;
                wstrb_r    <= WSTRB_IN;
            end
            if (do_write) begin
                AWREADY_OUT <= 1'b1;
                WREADY_OUT  <= 1'b1;
                BVALID_OUT  <= 1'b1;
                BRESP_OUT   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
            end
        end
    end

    // =====================================================
    // read channel: one outstanding read, data registered
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ARREADY_OUT <= 1'b1;
            RVALID_OUT  <= 1'b0;
            RDATA_OUT   <= '0;
            RRESP_OUT   <= RESP_OKAY;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b1;
            RDATA_OUT   <= rd_word(reg_sel(ARADDR_IN), ARADDR_IN[6:2]);
            RRESP_OUT   <= (reg_sel(ARADDR_IN) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT  <= 1'b0;
            ARREADY_OUT <= 1'b1;
        end
    end

    // =====================================================
    // event masks written by software
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            fovr_init_mask_r <= FOVR_MASK_RST;
            fovr_done_mask_r <= FOVR_MASK_RST;
            gsig_mask_r      <= GSIG_MASK_RST;
            irq_en_r         <= '0;
        end else if (do_write) begin
            if (wsel == SEL_FOVR) begin
                fovr_init_mask_r <= wnew[FOVR_INIT_LSB +: NUM_FOVR];
                fovr_done_mask_r <= wnew[FOVR_DONE_LSB +: NUM_FOVR];
            end
            if (wsel == SEL_GMSK) gsig_mask_r <= wnew[7:0];
            if (wsel == SEL_IEN) irq_en_r <= wnew[IRQ_W-1:0];
        end
    end

    // doorbell masks and message route controls
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_GDB; i++) begin
                odb_mask_r[i] <= DB_MASK_RST;
                idb_mask_r[i] <= DB_MASK_RST;
                msg_reg_r[i]  <= MSG_REG_RST;
                msg_target_partition_select_r[i] <= MSG_TARGET_PARTITION_SELECT_RST;
            end
        end else if (do_write) begin
            if (wsel == SEL_ODB) odb_mask_r[widx] <= wnew[7:0];
            if (wsel == SEL_IDB) idb_mask_r[widx] <= wnew[7:0];
            if (wsel == SEL_MSG) begin
                msg_reg_r[widx]  <= wnew[MSG_REG_LSB +: 2];
                msg_target_partition_select_r[widx] <= wnew[MSG_TARGET_PARTITION_SELECT_LSB +: 3];
            end
        end
    end

    // =====================================================
    // global signal status: set wins over a same-cycle clear
    assign gsig_set = GLOBAL_SIGNAL_IN & PARTITION_ENABLE_IN;
    always_comb begin
        gsig_nxt = gsig_sts_r;
        if (do_write && wsel == SEL_GSTS) gsig_nxt = gsig_nxt & ~wbits[7:0];
        gsig_nxt = (gsig_nxt | gsig_set) & PARTITION_ENABLE_IN;
    end

    // hold the status bits
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) gsig_sts_r <= GSIG_STS_RST;
        else        gsig_sts_r <= gsig_nxt;
    end

    // =====================================================
    // global doorbells: outbound requests merged, then fanned back out
    always_comb begin
        gdb_nxt = '0;
        ib_nxt  = '0;
        for (int g = 0; g < NUM_GDB; g++) begin
            for (int p = 0; p < NUM_TARGET_PARTITION_SELECT; p++) begin
                gdb_nxt[g] = gdb_nxt[g] | (OUTBOUND_DOORBELL_IN[p*NUM_GDB+g] & ~odb_mask_r[g][p]);
                ib_nxt[p*NUM_GDB+g] = gdb_sts_r[g] & ~idb_mask_r[g][p];
            end
        end
    end

    // doorbell state registers
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            gdb_sts_r            <= '0;
            INBOUND_DOORBELL_OUT <= '0;
        end else begin
            gdb_sts_r            <= gdb_nxt;
            INBOUND_DOORBELL_OUT <= ib_nxt;
        end
    end

    // =====================================================
    // message routing by the source's route control
    assign msg_idx = {MSG_SRC_TARGET_PARTITION_SELECT_IN, MSG_SRC_REG_IN};
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            MSG_VALID_OUT    <= 1'b0;
            MSG_DST_TARGET_PARTITION_SELECT_OUT <= '0;
            MSG_DST_REG_OUT  <= '0;
            MSG_DATA_OUT     <= '0;
        end else begin
            MSG_VALID_OUT <= MSG_VALID_IN;
            if (MSG_VALID_IN) begin
                MSG_DST_TARGET_PARTITION_SELECT_OUT <= msg_target_partition_select_r[msg_idx];
                MSG_DST_REG_OUT  <= msg_reg_r[msg_idx];
                MSG_DATA_OUT     <= MSG_DATA_IN;
            end
        end
    end

    // =====================================================
    // switch event from every unmasked source
    assign event_nxt = |(FAILOVER_INITIATED_IN & ~fovr_init_mask_r)
                     | |(FAILOVER_COMPLETED_IN & ~fovr_done_mask_r)
                     | |(gsig_sts_r & ~gsig_mask_r);

    // registered switch event
    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) SWITCH_EVENT_OUT <= 1'b0;
        else        SWITCH_EVENT_OUT <= event_nxt;
    end

    // =====================================================
    // interrupt: sticky events, write-one clear, enable gate
    assign irq_ev[IRQ_GSIG_BIT] = |(gsig_set & ~gsig_sts_r);
    assign irq_ev[IRQ_GDB_BIT]  = |(gdb_nxt & ~gdb_sts_r);
    assign irq_ev[IRQ_MSG_BIT]  = MSG_VALID_IN;

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            irq_sts_r <= '0;
            IRQ_OUT   <= 1'b0;
        end else begin
            if (do_write && wsel == SEL_ICLR) irq_sts_r <= (irq_sts_r & ~wbits[IRQ_W-1:0]) | irq_ev;
            else                              irq_sts_r <= irq_sts_r | irq_ev;
            IRQ_OUT <= |(irq_sts_r & irq_en_r);
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!rst_n);

    chk_fovr_init_gate: assert property (|(FAILOVER_INITIATED_IN & ~fovr_init_mask_r)
        |=> SWITCH_EVENT_OUT) else $error("unmasked initiated flag gave no event");
    chk_fovr_done_gate: assert property (($past(FAILOVER_COMPLETED_IN & ~fovr_done_mask_r) != '0)
        |-> SWITCH_EVENT_OUT) else $error("unmasked completed flag gave no event");
    chk_fovr_reserved: assert property ($rose(RVALID_OUT) && reg_sel($past(ARADDR_IN)) == SEL_FOVR
        |-> RDATA_OUT[15:4] == '0 && RDATA_OUT[31:20] == '0) else $error("reserved bits nonzero");
    chk_gsig_set: assert property (gsig_set != '0
        |=> (gsig_sts_r & $past(gsig_set)) == $past(gsig_set)) else $error("global signal not recorded");
    chk_gsig_disabled: assert property ((gsig_sts_r & ~$past(PARTITION_ENABLE_IN)) == '0)
        else $error("disabled partition status set");
    chk_gsig_masked: assert property ((gsig_sts_r & ~gsig_mask_r) != '0 |=> SWITCH_EVENT_OUT)
        else $error("unmasked global signal gave no event");
    chk_gdb_status: assert property (OUTBOUND_DOORBELL_IN[NUM_GDB+3] && !odb_mask_r[3][1]
        |=> gdb_sts_r[3]) else $error("doorbell status not set");
    chk_gdb_out_mask: assert property ((OUTBOUND_DOORBELL_IN == (DB_W'(1) << (NUM_GDB + 3)))
        && odb_mask_r[3][1] |=> !gdb_sts_r[3]) else $error("masked outbound doorbell reached status");
    chk_inbound_gate: assert property (##2 (INBOUND_DOORBELL_OUT[2*NUM_GDB+3] == ($past(gdb_sts_r[3], 1)
        & ~$past(idb_mask_r[3][2])))) else $error("inbound doorbell wrong");
    chk_msg_reg_sel: assert property (MSG_VALID_IN |=> MSG_VALID_OUT
        && MSG_DST_REG_OUT == $past(msg_reg_r[msg_idx])) else $error("message register wrong");
    chk_msg_target_partition_select_sel: assert property (MSG_VALID_IN |=> MSG_DST_TARGET_PARTITION_SELECT_OUT == $past(msg_target_partition_select_r[msg_idx])
        && MSG_DATA_OUT == $past(MSG_DATA_IN)) else $error("message partition wrong");
    chk_event_drop: assert property (!event_nxt ##1 !event_nxt |=> !SWITCH_EVENT_OUT)
        else $error("event stayed high");
    chk_write_answer: assert property (do_write |=> BVALID_OUT && AWREADY_OUT && WREADY_OUT)
        else $error("write not answered");

    cov_gsig_clear: cover property (gsig_sts_r != '0 ##[1:20] gsig_sts_r == '0);
    cov_event_rise: cover property ($rose(SWITCH_EVENT_OUT));
    cov_msg_routed: cover property (MSG_VALID_OUT && MSG_DST_TARGET_PARTITION_SELECT_OUT != '0);
    cov_bad_read:   cover property (RVALID_OUT && RRESP_OUT == RESP_SLVERR);
    cov_set_wins:   cover property (do_write && wsel == SEL_GSTS && (wbits[7:0] & gsig_set) != '0);
endmodule : partition_event_doorbell_routing

// ==== tb/tb_top.sv ====
// self-checking bench for the partition event and doorbell routing block
`timescale 1ns/1ps
module tb_top;
    import doorbell_route_pkg::*;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] rs;} row_t;
    logic clk, rst_n, awv, wv, bry, arv, rry, mv, awr, wr_, bv, arr, rv, mvo, sev, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, md, rd, mdo;
    logic [3:0] ws, fi, fc;
    logic [7:0] gs, pe;
    logic [1:0] br, rr, msr, mdr;
    logic [2:0] msp, mdp;
    logic [255:0] odb, idb;
    logic [1:0] resp;
    logic [31:0] val;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    // ====================================================
    // ordinary cases: reset values, reserved bits, read-only and unmapped places
    row_t rows[12] = '{
        '{0, 12'hC2C, 0, 32'h000F000F, 2'h0}, '{0, 12'hC30, 0, 32'h0, 2'h0},
        '{0, 12'hC34, 0, 32'hFF, 2'h0}, '{0, 12'hC3C, 0, 32'h0, 2'h0},
        '{0, 12'hD7C, 0, 32'h0, 2'h0}, '{0, 12'hDFC, 0, 32'h0, 2'h0},
        '{0, 12'hE3C, 0, 32'h0, 2'h0}, '{1, 12'hC2C, 32'hFFFFFFFF, 32'h000F000F, 2'h0},
        '{1, 12'hE24, 32'hFFFFFFFF, 32'h73, 2'h0}, '{1, 12'hD7C, 32'hFFFFFFFF, 32'hFF, 2'h0},
        '{1, 12'hC3C, 32'hFFFFFFFF, 32'h0, 2'h0}, '{1, 12'h004, 32'h1, 32'h0, 2'h2}};

    partition_event_doorbell_routing partition_event_doorbell_routing_i (
        .REF_CLK_IN(clk), .ARST_N_IN(rst_n), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
        .WDATA_IN(wd), .WSTRB_IN(ws), .WVALID_IN(wv), .WREADY_OUT(wr_), .BRESP_OUT(br), .BVALID_OUT(bv),
        .BREADY_IN(bry), .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rd),
        .RRESP_OUT(rr), .RVALID_OUT(rv), .RREADY_IN(rry), .FAILOVER_INITIATED_IN(fi),
        .FAILOVER_COMPLETED_IN(fc), .GLOBAL_SIGNAL_IN(gs), .PARTITION_ENABLE_IN(pe),
        .OUTBOUND_DOORBELL_IN(odb), .INBOUND_DOORBELL_OUT(idb), .MSG_VALID_IN(mv), .MSG_SRC_TARGET_PARTITION_SELECT_IN(msp),
        .MSG_SRC_REG_IN(msr), .MSG_DATA_IN(md), .MSG_VALID_OUT(mvo), .MSG_DST_TARGET_PARTITION_SELECT_OUT(mdp),
        .MSG_DST_REG_OUT(mdr), .MSG_DATA_OUT(mdo), .SWITCH_EVENT_OUT(sev), .IRQ_OUT(irq));

    // ====================================================
    // clock, verdict and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic test_done();
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ====================================================
    // register bus master: one write, then one read, each waits for its answer
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
            if (bv) begin
                r = br;
                bry <= 1'b0;
                break;
            end
        end
    endtask : axw
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                d = rd;
                r = rr;
                rry <= 1'b0;
                break;
            end
        end
    endtask : axr
    // settle a few cycles, then look at the switch event
    task automatic ev(input logic e);
        repeat (3) @(posedge clk);
        #1 chk("switch_event", sev, e);
    endtask : ev

    // ====================================================
    // main sequence
    initial begin
        rst_n = 1'b0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; mv = 0; awa = 0; ara = 0; wd = 0;
        md = 0; ws = 0; fi = 0; fc = 0; gs = 0; pe = 8'h0F; msr = 0; msp = 0; odb = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset_outputs", {sev, irq, mvo, bv, rv}, 5'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) axw(rows[i].a, rows[i].d, resp);
            if (rows[i].wr) chk("bresp", resp, rows[i].rs);
            axr(rows[i].a, val, resp);
            chk("rdata", val, rows[i].e);
            chk("rresp", resp, rows[i].rs);
        end
        axw(12'hE84, 32'h7, resp);
        // global signal: disabled partitions never set, write one clears
        @(posedge clk) gs <= 8'hFF;
        @(posedge clk) gs <= 8'h00;
        repeat (3) @(posedge clk);
        axr(12'hC30, val, resp);
        chk("gsig_status", val, 32'h0F);
        ev(1'b0);
        axw(12'hC34, 32'hFE, resp);
        ev(1'b1);
        axw(12'hC30, 32'h1, resp);
        axr(12'hC30, val, resp);
        chk("gsig_status", val, 32'h0E);
        ev(1'b0);
        // failover flags against their masks
        @(posedge clk) fi <= 4'h2;
        ev(1'b0);
        axw(12'hC2C, 32'h000F000D, resp);
        ev(1'b1);
        @(posedge clk) begin fi <= 4'h0; fc <= 4'h8; end
        ev(1'b0);
        axw(12'hC2C, 32'h0007000F, resp);
        ev(1'b1);
        @(posedge clk) fc <= 4'h0;
        ev(1'b0);
        // doorbells: partition 1 rings doorbell 3
        @(posedge clk) odb[35] <= 1'b1;
        repeat (4) @(posedge clk);
        axr(12'hC3C, val, resp);
        chk("gdb_status", val, 32'h8);
        chk("inbound", idb, {8{32'h8}});
        axw(12'hD8C, 32'h04, resp);
        repeat (3) @(posedge clk);
        chk("inbound_masked", idb, {{5{32'h8}}, 32'h0, {2{32'h8}}});
        axw(12'hD0C, 32'h02, resp);
        axr(12'hC3C, val, resp);
        chk("gdb_masked", val, 32'h0);
        // message route: partition 2 outbound 1 goes to partition 5 inbound 1
        axw(12'hE24, 32'h51, resp);
        @(posedge clk) begin mv <= 1'b1; msp <= 3'h2; msr <= 2'h1; md <= 32'hCAFE0001; end
        @(posedge clk) mv <= 1'b0;
        #1 chk("msg_route", {mvo, mdp, mdr, mdo}, {1'b1, 3'h5, 2'h1, 32'hCAFE0001});
        // interrupt: all three events latched, masked, then cleared
        repeat (2) @(posedge clk);
        axr(12'hE80, val, resp);
        chk("irq_status", {val, irq}, {32'h7, 1'b1});
        axw(12'hE84, 32'h0, resp);
        repeat (2) @(posedge clk);
        chk("irq_masked", irq, 1'b0);
        axw(12'hE88, 32'h7, resp);
        axr(12'hE80, val, resp);
        chk("irq_cleared", val, 32'h0);
        // reset mid-run restores the mask defaults
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset_outputs", {sev, irq, mvo, bv, rv}, 5'h0);
        axr(12'hC34, val, resp);
        chk("gsig_mask_rst", val, 32'hFF);
        chk("inbound_rst", idb, {8{32'h8}});
        // a clear that meets a new global signal loses to it
        @(posedge clk) gs <= 8'h01;
        axw(12'hC30, 32'h1, resp);
        axr(12'hC30, val, resp);
        chk("gsig_set_wins", val, 32'h1);
        test_done();
    end
endmodule : tb_top
